// [verilog/bcp_defs.svh]
// Timing and reset constants for the bearer channel process logic.
// Assumes a single 100 MHz clock; included by bare name.
`ifndef BCP_DEFS_SVH
`define BCP_DEFS_SVH

`define BCP_CLK_PERIOD_NS   10
`define BCP_TICK_MS         100
`define BCP_T145_MIN_MS     500
`define BCP_T145_MAX_MS     1500
`define BCP_T23_MS          2000
`define BCP_TICK_CYCLES     (`BCP_TICK_MS * 1000000 / `BCP_CLK_PERIOD_NS)
`define BCP_STEPS_RST       4'h0

`endif

// [verilog/bcp_pkg.sv]
// Types shared by the bearer channel process and its timer.
// Assumes nothing of its surroundings.
package bcp_pkg;

	typedef enum logic [2:0]
	{
		BCP_NULL     = 3'h0,
		BCP_WALLOC   = 3'h1,
		BCP_ABORT    = 3'h2,
		BCP_WDEALLOC = 3'h3,
		BCP_WAUDIT   = 3'h4
	} bcp_state_t;

	typedef enum logic [3:0]
	{
		BCP_M_ALLOC        = 4'h0,
		BCP_M_ALLOC_DONE   = 4'h1,
		BCP_M_ALLOC_REJ    = 4'h2,
		BCP_M_DEALLOC      = 4'h3,
		BCP_M_DEALLOC_DONE = 4'h4,
		BCP_M_DEALLOC_REJ  = 4'h5,
		BCP_M_AUDIT        = 4'h6,
		BCP_M_AUDIT_DONE   = 4'h7,
		BCP_M_AN_FAULT     = 4'h8,
		BCP_M_AN_FAULT_ACK = 4'h9,
		BCP_M_PROTO_ERR    = 4'hA
	} bcp_msg_t;

	typedef enum logic [1:0]
	{
		BCP_R_ALLOC   = 2'h0,
		BCP_R_DEALLOC = 2'h1,
		BCP_R_AUDIT   = 2'h2
	} bcp_req_t;

	typedef enum logic [3:0]
	{
		BCP_I_ALLOC_CONF   = 4'h0,
		BCP_I_ALLOC_REJ    = 4'h1,
		BCP_I_DEALLOC_CONF = 4'h2,
		BCP_I_DEALLOC_REJ  = 4'h3,
		BCP_I_AUDIT_CONF   = 4'h4,
		BCP_I_ALLOC_ERR    = 4'h5,
		BCP_I_DEALLOC_ERR  = 4'h6,
		BCP_I_AUDIT_ERR    = 4'h7,
		BCP_I_AN_FAULT     = 4'h8,
		BCP_I_PROTO_ERR    = 4'h9,
		BCP_I_PEER_ERR     = 4'hA
	} bcp_ind_t;

	typedef struct packed
	{
		logic     valid;
		bcp_msg_t msg;
		logic     extra_ie;
	} bcp_rx_t;

	typedef struct packed
	{
		logic     valid;
		bcp_req_t kind;
	} bcp_mreq_t;

	typedef struct packed
	{
		logic     valid;
		bcp_msg_t msg;
	} bcp_tx_t;

	typedef struct packed
	{
		logic     valid;
		bcp_ind_t code;
	} bcp_mind_t;

endpackage : bcp_pkg

// [verilog/bcp_timer.sv]
// Retry timer counted in 100 ms ticks, with its own tick divider.
// Assumes start and stop come from logic on the same clock.
`timescale 1ns/100ps
`include "bcp_defs.svh"

module bcp_timer
	import bcp_pkg::*;
#(
	parameter int TICK_CYCLES = `BCP_TICK_CYCLES
)
(
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	input  wire logic       start_in,
	input  wire logic       stop_in,
	input  wire logic [4:0] load_in,
	output logic            expire_out
);

	localparam int PW = $clog2(TICK_CYCLES);

	// A divider of one cycle would leave the prescaler without a terminal count
	if (TICK_CYCLES < 2)
	begin : g_bad_tick
		$error("bcp_timer: TICK_CYCLES must be at least 2");
	end

	typedef struct packed
	{
		logic [PW-1:0] presc;
		logic [4:0]    ticks;
		logic          run;
		logic          expire;
	} bcp_tmr_st_t;

	bcp_tmr_st_t r_reg;
	bcp_tmr_st_t r_next;

	// The divider restarts with the timer, so no partial tick shortens a timeout
	// tick derived count
	always_comb
	begin
		r_next        = r_reg;
		r_next.expire = 1'b0;
		if (start_in)
		begin
			r_next.run   = 1'b1;
			r_next.presc = '0;
			r_next.ticks = load_in;
		end
		else if (stop_in)
			r_next.run = 1'b0;
		else if (r_reg.run)
		begin
			if (r_reg.presc == PW'(TICK_CYCLES - 1))
			begin
				r_next.presc = '0;
				if (r_reg.ticks <= 5'h01)
				begin
					r_next.run    = 1'b0;
					r_next.expire = 1'b1;
				end
				else
					r_next.ticks = r_reg.ticks - 5'h01;
			end
			else
				r_next.presc = r_reg.presc + PW'(1);
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			r_reg <= '0;
		else
			r_reg <= r_next;
	end

	assign expire_out = r_reg.expire;

	logic [31:0] cyc_reg;
	logic [4:0]  load_reg;

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			cyc_reg  <= 32'h0000_0000;
			load_reg <= 5'h00;
		end
		else if (start_in)
		begin
			cyc_reg  <= 32'h0000_0000;
			load_reg <= load_in;
		end
		else if (r_reg.run)
			cyc_reg <= cyc_reg + 32'h0000_0001;
	end

	chk_expiry_exact_time: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		expire_out |-> cyc_reg == 32'(load_reg) * 32'(TICK_CYCLES))
		else $error("timer expired at the wrong cycle count");

endmodule : bcp_timer

// [verilog/bcp_le_process.sv]
// One exchange-side bearer channel connection process with its retry timer.
// Assumes link messages arrive already decoded, and management requests come
// from logic on the same clock; one instance per process.
//
// Behaviour
// - Access side reports, drops and answers unexpected messages; this end never answers.
// - Unexpected message: keep state, indicate protocol error, drop, no reply.
// - Too many optional elements: indicate protocol error, drop whole message.
// - Every timer expires within ten percent of its configured timeout.
// - Allocation and audit timers share one timeout, 500 to 1500 ms, 100 ms steps.
// - First expiry resends and restarts; second expiry ends procedure, notifies management.
// - This end owns the allocation, abort, de-allocation and audit timers only.
// - Each process is a separate instance with own state and timer.
// - Null: allocation or audit request sends message, starts timer, waits.
// - De-allocation request from null or waiting allocation; two second timers.
// - Completion or reject answers confirm, stop timer, return null; null reports only.
// - Peer fault report in null is acknowledged and indicated to management.
`timescale 1ns/100ps
`include "bcp_defs.svh"

module bcp_le_process
	import bcp_pkg::*;
#(
	parameter int TICK_CYCLES = `BCP_TICK_CYCLES
)
(
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	input  wire logic [3:0] cfg_steps_in,
	input  wire bcp_rx_t    rx_in,
	output logic            rx_ready_out,
	input  wire bcp_mreq_t  req_in,
	output logic            req_ready_out,
	output bcp_tx_t         tx_out,
	output bcp_mind_t       ind_out,
	output bcp_state_t      state_out
);

	localparam logic [4:0] T23_TICKS  = 5'(`BCP_T23_MS / `BCP_TICK_MS);
	localparam logic [3:0] STEPS_MIN  = 4'(`BCP_T145_MIN_MS / `BCP_TICK_MS);
	localparam logic [3:0] STEPS_MAX  = 4'(`BCP_T145_MAX_MS / `BCP_TICK_MS);

	typedef struct packed
	{
		bcp_state_t state;
		logic       second;
		bcp_tx_t    tx;
		bcp_mind_t  ind;
		logic       tmr_start;
		logic       tmr_stop;
		logic [4:0] tmr_load;
	} bcp_le_st_t;

	bcp_le_st_t r_reg;
	bcp_le_st_t r_next;
	logic       expire;
	logic       rx_take;
	logic       req_take;

	// Out-of-range settings are clamped rather than refused, so a timer always runs
	// common clamped timeout
	function automatic logic [4:0] common_ticks(input logic [3:0] steps);
		logic [3:0] s;
		s = steps;
		if (s < STEPS_MIN)
			s = STEPS_MIN;
		else if (s > STEPS_MAX)
			s = STEPS_MAX;
		return {1'b0, s};
	endfunction : common_ticks

	// Expiry cannot wait, so it outranks link messages, which outrank requests
	assign rx_ready_out  = ~expire;
	assign req_ready_out = ~expire & ~rx_in.valid;
	assign rx_take       = rx_in.valid & ~expire;
	assign req_take      = req_in.valid & ~expire & ~rx_in.valid;

	always_comb
	begin
		r_next           = r_reg;
		r_next.tx.valid  = 1'b0;
		r_next.ind.valid = 1'b0;
		r_next.tmr_start = 1'b0;
		r_next.tmr_stop  = 1'b0;
		if (expire && r_reg.state != BCP_NULL)
		begin
			if (!r_reg.second)
			begin
				r_next.second    = 1'b1;
				r_next.tx.valid  = 1'b1;
				r_next.tmr_start = 1'b1;
				case (r_reg.state)
					BCP_WALLOC: r_next.tx.msg = BCP_M_ALLOC;
					BCP_WAUDIT: r_next.tx.msg = BCP_M_AUDIT;
					default:    r_next.tx.msg = BCP_M_DEALLOC;
				endcase
			end
			else
			begin
				r_next.second    = 1'b0;
				r_next.state     = BCP_NULL;
				r_next.ind.valid = 1'b1;
				case (r_reg.state)
					BCP_WALLOC: r_next.ind.code = BCP_I_ALLOC_ERR;
					BCP_WAUDIT: r_next.ind.code = BCP_I_AUDIT_ERR;
					default:    r_next.ind.code = BCP_I_DEALLOC_ERR;
				endcase
			end
		end
		else if (rx_take)
		begin
			r_next.ind.valid = 1'b1;
			r_next.ind.code  = BCP_I_PROTO_ERR;
			if (!rx_in.extra_ie)
			begin
				case (rx_in.msg)
					BCP_M_ALLOC_DONE, BCP_M_ALLOC_REJ:
					begin
						if (r_reg.state == BCP_WALLOC || r_reg.state == BCP_NULL)
							r_next.ind.code = (rx_in.msg == BCP_M_ALLOC_DONE) ?
								BCP_I_ALLOC_CONF : BCP_I_ALLOC_REJ;
						if (r_reg.state == BCP_WALLOC)
							r_next.state = BCP_NULL;
					end
					BCP_M_DEALLOC_DONE, BCP_M_DEALLOC_REJ:
					begin
						if (r_reg.state inside {BCP_ABORT, BCP_WDEALLOC, BCP_NULL})
							r_next.ind.code = (rx_in.msg == BCP_M_DEALLOC_DONE) ?
								BCP_I_DEALLOC_CONF : BCP_I_DEALLOC_REJ;
						if (r_reg.state inside {BCP_ABORT, BCP_WDEALLOC})
							r_next.state = BCP_NULL;
					end
					BCP_M_AUDIT_DONE:
					begin
						if (r_reg.state == BCP_WAUDIT)
						begin
							r_next.ind.code = BCP_I_AUDIT_CONF;
							r_next.state    = BCP_NULL;
						end
					end
					BCP_M_AN_FAULT:
					begin
						if (r_reg.state == BCP_NULL)
						begin
							r_next.ind.code = BCP_I_AN_FAULT;
							r_next.tx.valid = 1'b1;
							r_next.tx.msg   = BCP_M_AN_FAULT_ACK;
						end
					end
					BCP_M_PROTO_ERR:
					begin
						if (r_reg.state != BCP_NULL)
						begin
							r_next.ind.code = BCP_I_PEER_ERR;
							r_next.state    = BCP_NULL;
						end
					end
					default:
						r_next.ind.code = BCP_I_PROTO_ERR;
				endcase
				if (r_reg.state != BCP_NULL && r_next.state == BCP_NULL)
				begin
					r_next.tmr_stop = 1'b1;
					r_next.second   = 1'b0;
				end
			end
		end
		else if (req_take)
		begin
			case (req_in.kind)
				BCP_R_ALLOC:
				begin
					if (r_reg.state == BCP_NULL)
					begin
						r_next.tx.valid  = 1'b1;
						r_next.tx.msg    = BCP_M_ALLOC;
						r_next.tmr_start = 1'b1;
						r_next.tmr_load  = common_ticks(cfg_steps_in);
						r_next.state     = BCP_WALLOC;
						r_next.second    = 1'b0;
					end
				end
				BCP_R_DEALLOC:
				begin
					// de-allocation start; a restart also drops the allocation timer
					if (r_reg.state == BCP_NULL || r_reg.state == BCP_WALLOC)
					begin
						r_next.tx.valid  = 1'b1;
						r_next.tx.msg    = BCP_M_DEALLOC;
						r_next.tmr_start = 1'b1;
						r_next.tmr_load  = T23_TICKS;
						r_next.second    = 1'b0;
						r_next.state     = (r_reg.state == BCP_NULL) ? BCP_WDEALLOC : BCP_ABORT;
					end
				end
				BCP_R_AUDIT:
				begin
					if (r_reg.state == BCP_NULL)
					begin
						r_next.tx.valid  = 1'b1;
						r_next.tx.msg    = BCP_M_AUDIT;
						r_next.tmr_start = 1'b1;
						r_next.tmr_load  = common_ticks(cfg_steps_in);
						r_next.state     = BCP_WAUDIT;
						r_next.second    = 1'b0;
					end
				end
				default:
					r_next.state = r_reg.state;
			endcase
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			r_reg          <= '0;
			r_reg.tmr_load <= common_ticks(`BCP_STEPS_RST);
		end
		else
			r_reg <= r_next;
	end

	bcp_timer #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_timer (
		.clk_in     (clk_in),
		.rst_n_in   (rst_n_in),
		.start_in   (r_reg.tmr_start),
		.stop_in    (r_reg.tmr_stop),
		.load_in    (r_reg.tmr_load),
		.expire_out (expire)
	);

	assign tx_out    = r_reg.tx;
	assign ind_out   = r_reg.ind;
	assign state_out = r_reg.state;

	chk_extra_ie_drop: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		rx_take && rx_in.extra_ie |=> ind_out.valid && ind_out.code == BCP_I_PROTO_ERR
			&& !tx_out.valid && state_out == $past(state_out))
		else $error("surplus elements not dropped");

	chk_perr_no_reply: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		ind_out.valid && ind_out.code == BCP_I_PROTO_ERR
			|-> !tx_out.valid && state_out == $past(state_out))
		else $error("protocol error changed state or replied");

	chk_alloc_start: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		req_take && req_in.kind == BCP_R_ALLOC && state_out == BCP_NULL
			|=> tx_out.valid && tx_out.msg == BCP_M_ALLOC && state_out == BCP_WALLOC
			&& r_reg.tmr_start && r_reg.tmr_load >= 5'h05 && r_reg.tmr_load <= 5'h0F)
		else $error("allocation request mishandled");

	chk_audit_start: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		req_take && req_in.kind == BCP_R_AUDIT && state_out == BCP_NULL
			|=> tx_out.msg == BCP_M_AUDIT && state_out == BCP_WAUDIT && r_reg.tmr_start)
		else $error("audit request mishandled");

	chk_dealloc_abort: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		req_take && req_in.kind == BCP_R_DEALLOC && state_out == BCP_WALLOC
			|=> state_out == BCP_ABORT && tx_out.msg == BCP_M_DEALLOC
			&& r_reg.tmr_load == 5'h14)
		else $error("abort de-allocation mishandled");

	chk_first_expiry: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		expire && !r_reg.second && state_out != BCP_NULL
			|=> tx_out.valid && r_reg.second && r_reg.tmr_start
			&& state_out == $past(state_out))
		else $error("first expiry did not resend");

	chk_second_expiry: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		expire && r_reg.second && state_out != BCP_NULL
			|=> state_out == BCP_NULL && ind_out.valid && !tx_out.valid)
		else $error("second expiry did not conclude");

	chk_null_answer: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		rx_take && !rx_in.extra_ie && rx_in.msg == BCP_M_ALLOC_DONE && state_out == BCP_NULL
			|=> state_out == BCP_NULL && ind_out.code == BCP_I_ALLOC_CONF && !r_reg.tmr_stop)
		else $error("answer in null mishandled");

	chk_fault_ack: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		rx_take && !rx_in.extra_ie && rx_in.msg == BCP_M_AN_FAULT && state_out == BCP_NULL
			|=> tx_out.valid && tx_out.msg == BCP_M_AN_FAULT_ACK ##1 !tx_out.valid)
		else $error("peer fault not acknowledged");

endmodule : bcp_le_process

// [tb/bcp_an_peer.sv]
// Access-side peer model: answers exchange messages after a delay while ans_in is valid.
// Assumes the bench sets ans_in and dly_in between exchanges.
`timescale 1ns/100ps

module bcp_an_peer
	import bcp_pkg::*;
(
	input  wire logic       clk_in,
	input  wire bcp_tx_t    tx_in,
	input  wire logic       rdy_in,
	input  wire bcp_rx_t    ans_in,
	input  wire logic [3:0] dly_in,
	output bcp_rx_t         rx_out
);
	bcp_rx_t a;

	initial rx_out = '0;

	// Hold until taken or 50 cycles pass, then scramble so a stale message never passes
	task automatic send(input bcp_msg_t m, input logic x);
		int n;
		@(negedge clk_in);
		rx_out = {1'b1, m, x};
		for (n = 0; n < 50; n++)
		begin
			@(posedge clk_in);
			if (rdy_in === 1'b1)
				break;
		end
		@(negedge clk_in);
		rx_out = {1'b0, ~m, ~x};
	endtask : send

	task automatic fault(output logic ok);
		int n;
		send(BCP_M_AN_FAULT, 1'b0);
		ok = 1'b0;
		for (n = 0; n < 8 && !ok; n++)
		begin
			ok = tx_in.valid === 1'b1 && tx_in.msg === BCP_M_AN_FAULT_ACK;
			@(negedge clk_in);
		end
	endtask : fault

	// Prompt or slow answers; no answer at all lets retries run
	always @(posedge clk_in)
		if (tx_in.valid === 1'b1 && ans_in.valid === 1'b1)
		begin
			a = ans_in;
			repeat (dly_in) @(posedge clk_in);
			send(a.msg, a.extra_ie);
		end
endmodule : bcp_an_peer

// [tb/bcp_le_process_bench.sv]
// Bench for one exchange-side bearer channel process facing a peer model.
// Assumes a 4-cycle tick so retry timeouts run in tens of cycles.
`timescale 1ns/100ps

module bcp_le_process_bench
	import bcp_pkg::*;
;
	localparam int TC = 4;
	localparam bcp_req_t AK[6] = '{BCP_R_ALLOC, BCP_R_ALLOC, BCP_R_DEALLOC,
		BCP_R_DEALLOC, BCP_R_AUDIT, BCP_R_ALLOC};
	localparam bcp_msg_t AA[6] = '{BCP_M_ALLOC_DONE, BCP_M_ALLOC_REJ, BCP_M_DEALLOC_DONE,
		BCP_M_DEALLOC_REJ, BCP_M_AUDIT_DONE, BCP_M_PROTO_ERR};
	localparam logic [3:0] AI[6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'hA};
	localparam bcp_msg_t DM[8] = '{BCP_M_AUDIT_DONE, BCP_M_ALLOC_DONE, BCP_M_ALLOC_REJ,
		BCP_M_DEALLOC_DONE, BCP_M_DEALLOC_REJ, BCP_M_PROTO_ERR, BCP_M_AN_FAULT_ACK,
		BCP_M_ALLOC_DONE};
	localparam logic [3:0] DI[8] = '{4'h9, 4'h0, 4'h1, 4'h2, 4'h3, 4'h9, 4'h9, 4'h9};

	logic       clk_in   = 1'b0;
	logic       rst_n_in = 1'b0;
	logic [3:0] cfg      = 4'h5;
	logic [3:0] dly      = 4'h1;
	bcp_rx_t    ans      = '0;
	bcp_mreq_t  req      = '0;
	bcp_rx_t    rx;
	bcp_tx_t    tx;
	bcp_mind_t  ind;
	bcp_state_t st;
	bcp_req_t   k;
	logic       rx_rdy, req_rdy, ok;
	logic [4:0] q[$];
	int         miscompares = 0, checked = 0, cyc = 0, i, d, lt;

	always #5 clk_in = ~clk_in;
	always @(posedge clk_in) cyc++;

	bcp_le_process #(.TICK_CYCLES(TC)) u_bcp_le_process (.clk_in(clk_in),
		.rst_n_in(rst_n_in), .cfg_steps_in(cfg), .rx_in(rx), .rx_ready_out(rx_rdy),
		.req_in(req), .req_ready_out(req_rdy), .tx_out(tx), .ind_out(ind), .state_out(st));
	bcp_an_peer u_bcp_an_peer (.clk_in(clk_in), .tx_in(tx), .rdy_in(rx_rdy),
		.ans_in(ans), .dly_in(dly), .rx_out(rx));

	task automatic end_of_test;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_of_test

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			miscompares++;
			$display("BAD %s expected %0h seen %0h", n, e, g);
		end
	endtask : chk

	task automatic fail(input string n);
		miscompares++;
		$display("BAD %s expected done seen timeout", n);
		end_of_test();
	endtask : fail

	function automatic logic [4:0] txm(input bcp_req_t r);
		return {1'b1, r == BCP_R_ALLOC ? BCP_M_ALLOC
			: r == BCP_R_AUDIT ? BCP_M_AUDIT : BCP_M_DEALLOC};
	endfunction : txm

	// Mode 1 is a de-allocation that aborts, mode 2 a request that is ignored
	task automatic go(input bcp_req_t r, input int m);
		int n;
		if (m != 2)
			q.push_back(txm(r));
		@(negedge clk_in);
		req = {1'b1, r};
		for (n = 0; n < 20; n++)
		begin
			@(posedge clk_in);
			if (req_rdy === 1'b1)
				break;
		end
		@(negedge clk_in);
		req = {1'b0, ~r};
		if (n == 20)
			fail("request");
		chk("state", m == 2 || r == BCP_R_ALLOC ? BCP_WALLOC : r == BCP_R_AUDIT ? BCP_WAUDIT
			: m ? BCP_ABORT : BCP_WDEALLOC, st);
	endtask : go

	task automatic wst(input int lim);
		int n;
		for (n = 0; n < lim && st !== BCP_NULL; n++)
			@(negedge clk_in);
		if (n == lim)
			fail("null wait");
	endtask : wst

	task automatic drain;
		repeat (6) @(negedge clk_in);
		chk("pending", 0, q.size());
	endtask : drain

	// Each pulse takes the oldest note; a pulse with no note is a mismatch
	always @(negedge clk_in)
	begin
		if (tx.valid === 1'b1)
			chk("tx", q.size() ? q.pop_front() : 5'h1F, {1'b1, tx.msg});
		if (ind.valid === 1'b1)
			chk("ind", q.size() ? q.pop_front() : 5'h1F, {1'b0, ind.code});
	end

	initial
	begin
		d = $urandom(32'h743b69b2);
		repeat (4) @(posedge clk_in);
		@(negedge clk_in);
		rst_n_in = 1'b1;
		chk("reset state", BCP_NULL, st);
		for (i = 0; i < 6; i++)
		begin
			dly = 4'($urandom_range(6));
			ans = {1'b1, AA[i], 1'b0};
			go(AK[i], 0); // request sent
			q.push_back({1'b0, AI[i]});
			wst(40); // back to null
			drain(); // answer reported
		end
		ans.valid = 1'b0;
		for (i = 0; i < 5; i++)
		begin
			k = i < 3 ? BCP_R_ALLOC : i == 3 ? BCP_R_AUDIT : BCP_R_DEALLOC;
			cfg = i == 0 ? 4'h4 : i == 2 ? 4'hF : 4'($urandom_range(15, 5));
			lt = TC * (k == BCP_R_DEALLOC ? 20 : cfg < 5 ? 5 : cfg);
			d = cyc;
			go(k, 0); // request sent
			q.push_back(txm(k));
			q.push_back({1'b0, k == BCP_R_ALLOC ? BCP_I_ALLOC_ERR
				: k == BCP_R_AUDIT ? BCP_I_AUDIT_ERR : BCP_I_DEALLOC_ERR});
			wst(3 * lt + 20);
			d = cyc - d;
			chk("timeout", 1, d >= 2 * lt + 2 && d <= 2 * lt + 8);
			drain(); // resend then error
		end
		go(BCP_R_ALLOC, 0);
		@(negedge clk_in);
		ans = {1'b1, BCP_M_DEALLOC_REJ, 1'b0};
		go(BCP_R_DEALLOC, 1); // abort entered
		q.push_back({1'b0, BCP_I_DEALLOC_REJ});
		wst(40);
		drain(); // abort answered
		ans.valid = 1'b0;
		for (i = 0; i < 8; i++)
		begin
			q.push_back({1'b0, DI[i]});
			u_bcp_an_peer.send(DM[i], i == 7); // null events
			chk("state", BCP_NULL, st); // state kept
			drain();
		end
		cfg = 4'hF;
		go(BCP_R_ALLOC, 0);
		for (i = 0; i < 3; i++)
		begin
			q.push_back({1'b0, BCP_I_PROTO_ERR});
			u_bcp_an_peer.send(i == 0 ? BCP_M_DEALLOC_DONE : i == 1 ? BCP_M_ALLOC_DONE
				: BCP_M_AN_FAULT, i == 1); // dropped
			chk("state", BCP_WALLOC, st); // state kept
		end
		go(BCP_R_AUDIT, 2);
		q.push_back({1'b0, BCP_I_ALLOC_CONF});
		u_bcp_an_peer.send(BCP_M_ALLOC_DONE, 1'b0); // late answer
		wst(8);
		drain(); // own state only
		q.push_back({1'b1, BCP_M_AN_FAULT_ACK});
		q.push_back({1'b0, BCP_I_AN_FAULT});
		u_bcp_an_peer.fault(ok);
		chk("fault ack", 1, ok); // ack returned
		drain();
		end_of_test();
	end
endmodule : bcp_le_process_bench
